// *** logic/vbrc_pkg.sv ***
// Constants and types shared by the vector base and reset control block
package vbrc_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] VTB_OFFSET = 8'h08;
    localparam logic [7:0] AIRC_OFFSET = 8'h0C;
    // Key values of the control register
    localparam logic [15:0] KEY_WRITE = 16'h05FA;
    localparam logic [15:0] KEY_READ = 16'hFA05;
    // Field positions of the vector table base register
    localparam int REGION_BIT = 29;
    localparam int OFF_HI = 28;
    localparam int OFF_LO = 7;
    // Field positions of the control register
    localparam int KEY_HI = 31;
    localparam int KEY_LO = 16;
    localparam int ENDIAN_BIT = 15;
    localparam int SPLIT_HI = 10;
    localparam int SPLIT_LO = 8;
    localparam int WARM_BIT = 2;
    localparam int CLR_BIT = 1;
    localparam int CORE_RST_BIT = 0;
    // Reset values
    localparam logic [21:0] OFFSET_RESET = 22'h000000;
    localparam logic [2:0] SPLIT_RESET = 3'h0;
    // Region start addresses (plain defaults)
    localparam logic [31:0] CODE_REGION_BASE = 32'h00000000;
    localparam logic [31:0] SRAM_REGION_BASE = 32'h20000000;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Priority value width
    localparam int PRIO_W = 8;

    // Captured address phase
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [2:0] size;
    } vbrc_aphase_t;
endpackage : vbrc_pkg

// *** logic/vbrc_prio_split.sv ***
// Splits one priority value into pre-emption level and subpriority
`timescale 1ns/1ps
module vbrc_prio_split #(
    parameter int PW = 8
) (
    input wire logic [2:0] split_select,
    input wire logic [PW-1:0] priority_in,
    output logic [PW-1:0] preempt_level,
    output logic [PW-1:0] sub_priority
);
    // Subpriority mask: select 0 keeps one low bit, 7 keeps all eight
    function automatic logic [PW-1:0] sub_mask(input logic [2:0] sel);
        logic [PW-1:0] ones;
        ones = {PW{1'b1}};
        sub_mask = ~(PW'(ones << 1) << sel);
    endfunction : sub_mask

    // Field split
    assign preempt_level = priority_in & ~sub_mask(split_select);
    assign sub_priority = priority_in & sub_mask(split_select);
endmodule : vbrc_prio_split

// *** logic/vbrc_top.sv ***
// Vector table base and keyed interrupt/reset control registers on AHB-Lite
`timescale 1ns/1ps
module vbrc_top #(
    parameter logic BIG_ENDIAN = 1'b0,
    parameter logic [31:0] CODE_BASE = vbrc_pkg::CODE_REGION_BASE,
    parameter logic [31:0] SRAM_BASE = vbrc_pkg::SRAM_REGION_BASE
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] vector_base_addr,
    output logic byte_order_flag,
    output logic [2:0] priority_split_select,
    output logic warm_reset_request,
    output logic clear_active_state,
    output logic core_system_reset,
    input wire logic [7:0] priority_a,
    input wire logic [7:0] priority_b,
    output logic a_preempts_b,
    output logic a_before_b
);
    localparam int PW = vbrc_pkg::PRIO_W;

    vbrc_pkg::vbrc_aphase_t aphase_reg;
    logic dphase_reg;
    logic region_reg;
    logic [21:0] offset_reg;
    logic [2:0] split_reg;
    logic warm_reg;
    logic clr_reg;
    logic core_rst_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] base_reg;
    logic a_preempts_reg;
    logic a_before_reg;
    logic take_aphase;
    logic wr_ok;
    logic vtb_wr;
    logic airc_wr;
    logic key_ok;
    logic [31:0] vtb_rd;
    logic [31:0] airc_rd;
    logic [PW-1:0] pre_lvl [2];
    logic [PW-1:0] sub_lvl [2];
    logic [PW-1:0] prio_in [2];

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take_aphase = hsel && hready && (htrans == vbrc_pkg::HTRANS_NONSEQ);

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_reg <= 1'b0;
            aphase_reg <= '0;
        end else if (hready) begin
            dphase_reg <= take_aphase;
            aphase_reg <= '{addr: haddr[7:0], write: hwrite, size: hsize};
        end
    end

    // Write decode in data phase, whole words only
    assign wr_ok = dphase_reg && aphase_reg.write && (aphase_reg.size == vbrc_pkg::HSIZE_WORD);
    assign vtb_wr = wr_ok && (aphase_reg.addr == vbrc_pkg::VTB_OFFSET);
    assign key_ok = hwdata[vbrc_pkg::KEY_HI:vbrc_pkg::KEY_LO] == vbrc_pkg::KEY_WRITE;
    assign airc_wr = wr_ok && (aphase_reg.addr == vbrc_pkg::AIRC_OFFSET) && key_ok;

    // Vector table base fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            region_reg <= 1'b0;
            offset_reg <= vbrc_pkg::OFFSET_RESET;
        end else if (vtb_wr) begin
            region_reg <= hwdata[vbrc_pkg::REGION_BIT];
            offset_reg <= hwdata[vbrc_pkg::OFF_HI:vbrc_pkg::OFF_LO];
        end
    end

    // Keyed control fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            split_reg <= vbrc_pkg::SPLIT_RESET;
        end else if (airc_wr) begin
            split_reg <= hwdata[vbrc_pkg::SPLIT_HI:vbrc_pkg::SPLIT_LO];
        end
    end

    // Warm reset request, held until the reset it causes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warm_reg <= 1'b0;
        end else if (airc_wr && hwdata[vbrc_pkg::WARM_BIT]) begin
            warm_reg <= 1'b1;
        end
    end

    // Self-clearing one-cycle actions
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clr_reg <= 1'b0;
            core_rst_reg <= 1'b0;
        end else begin
            clr_reg <= airc_wr && hwdata[vbrc_pkg::CLR_BIT];
            core_rst_reg <= airc_wr && hwdata[vbrc_pkg::CORE_RST_BIT];
        end
    end

    // Read views, reserved bits zero
    always_comb begin
        vtb_rd = '0;
        vtb_rd[vbrc_pkg::REGION_BIT] = region_reg;
        vtb_rd[vbrc_pkg::OFF_HI:vbrc_pkg::OFF_LO] = offset_reg;
        airc_rd = '0;
        airc_rd[vbrc_pkg::KEY_HI:vbrc_pkg::KEY_LO] = vbrc_pkg::KEY_READ;
        airc_rd[vbrc_pkg::ENDIAN_BIT] = BIG_ENDIAN;
        airc_rd[vbrc_pkg::SPLIT_HI:vbrc_pkg::SPLIT_LO] = split_reg;
        airc_rd[vbrc_pkg::WARM_BIT] = warm_reg;
        airc_rd[vbrc_pkg::CLR_BIT] = clr_reg;
        airc_rd[vbrc_pkg::CORE_RST_BIT] = core_rst_reg;
    end

    // Read data loaded at the address phase edge; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= '0;
        end else if (take_aphase && !hwrite) begin
            if (haddr[7:0] == vbrc_pkg::VTB_OFFSET) begin
                hrdata_reg <= vtb_rd;
            end else if (haddr[7:0] == vbrc_pkg::AIRC_OFFSET) begin
                hrdata_reg <= airc_rd;
            end else begin
                hrdata_reg <= '0;
            end
        end
    end
    assign hrdata = hrdata_reg;

    // Vector table base address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_reg <= '0;
        end else begin
            base_reg <= (region_reg ? SRAM_BASE : CODE_BASE)
                + {3'h0, offset_reg, 7'h00};
        end
    end

    // Priority split of both candidates
    assign prio_in[0] = priority_a;
    assign prio_in[1] = priority_b;
    for (genvar i = 0; i < 2; i++) begin : g_split
        vbrc_prio_split #(.PW(PW)) u_split (
            .split_select(split_reg),
            .priority_in(prio_in[i]),
            .preempt_level(pre_lvl[i]),
            .sub_priority(sub_lvl[i])
        );
    end

    // Comparison: lower number wins; subpriority only breaks equal levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_preempts_reg <= 1'b0;
            a_before_reg <= 1'b0;
        end else begin
            a_preempts_reg <= pre_lvl[0] < pre_lvl[1];
            a_before_reg <= (pre_lvl[0] < pre_lvl[1])
                || ((pre_lvl[0] == pre_lvl[1]) && (sub_lvl[0] < sub_lvl[1]));
        end
    end

    assign vector_base_addr = base_reg;
    assign byte_order_flag = BIG_ENDIAN;
    assign priority_split_select = split_reg;
    assign warm_reset_request = warm_reg;
    assign clear_active_state = clr_reg;
    assign core_system_reset = core_rst_reg;
    assign a_preempts_b = a_preempts_reg;
    assign a_before_b = a_before_reg;

    // Checks
    property p_key_read;
        @(posedge hclk) disable iff (!hresetn)
        (take_aphase && !hwrite && haddr[7:0] == vbrc_pkg::AIRC_OFFSET)
            |=> hrdata[31:16] == 16'hFA05;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key status wrong");

    property p_bad_key;
        @(posedge hclk) disable iff (!hresetn)
        (wr_ok && aphase_reg.addr == vbrc_pkg::AIRC_OFFSET && hwdata[31:16] != 16'h05FA)
            |=> $stable(split_reg) && !clr_reg && !core_rst_reg && $stable(warm_reg);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("unkeyed write acted");

    property p_good_key;
        @(posedge hclk) disable iff (!hresetn)
        (wr_ok && aphase_reg.addr == vbrc_pkg::AIRC_OFFSET && hwdata[31:16] == 16'h05FA)
            |=> split_reg == $past(hwdata[10:8]);
    endproperty
    a_good_key: assert property (p_good_key) else $error("keyed write lost");

    property p_clr_pulse;
        @(posedge hclk) disable iff (!hresetn)
        $rose(clear_active_state) |=> !clear_active_state;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clear not self clearing");

    property p_core_rst;
        @(posedge hclk) disable iff (!hresetn)
        (airc_wr && hwdata[0]) |=> core_system_reset ##1 !core_system_reset;
    endproperty
    a_core_rst: assert property (p_core_rst) else $error("core reset pulse wrong");

    property p_warm_hold;
        @(posedge hclk) disable iff (!hresetn)
        warm_reset_request |=> warm_reset_request;
    endproperty
    a_warm_hold: assert property (p_warm_hold) else $error("warm request dropped");

    property p_base;
        @(posedge hclk) disable iff (!hresetn)
        vtb_wr ##1 !vtb_wr |=> vector_base_addr ==
            ($past(hwdata[29], 2) ? SRAM_BASE : CODE_BASE) + {3'h0, $past(hwdata[28:7], 2), 7'h00};
    endproperty
    a_base: assert property (p_base) else $error("vector base wrong");

    property p_vtb_reserved;
        @(posedge hclk) disable iff (!hresetn)
        (take_aphase && !hwrite && haddr[7:0] == vbrc_pkg::VTB_OFFSET)
            |=> hrdata[31:30] == 2'h0 && hrdata[6:0] == 7'h00;
    endproperty
    a_vtb_reserved: assert property (p_vtb_reserved) else $error("reserved bits set");

    property p_endian;
        @(posedge hclk) disable iff (!hresetn)
        (take_aphase && !hwrite && haddr[7:0] == vbrc_pkg::AIRC_OFFSET)
            |=> hrdata[15] == BIG_ENDIAN && hrdata[14:11] == 4'h0;
    endproperty
    a_endian: assert property (p_endian) else $error("byte order readback wrong");

    property p_split_order;
        @(posedge hclk) disable iff (!hresetn)
        (split_reg == 3'h7) |=> !a_preempts_b;
    endproperty
    a_split_order: assert property (p_split_order) else $error("preempt with no levels");
endmodule : vbrc_top

// *** testbench/vbrc_core_model.sv ***
// Core-side model: counts action pulses and answers a warm reset request
`timescale 1ns/1ps
module vbrc_core_model #(
    parameter int DLY = 3
) (
    input wire logic hclk,
    input wire logic warm_reset_request,
    input wire logic clear_active_state,
    input wire logic core_system_reset,
    output logic warm_rst_n,
    output int n_clear,
    output int n_core
);
    // Idle state at time zero, each variable owned by one process
    int cnt = 0;
    int clr_cnt = 0;
    int core_cnt = 0;
    logic rst_q = 1'b1;
    assign n_clear = clr_cnt;
    assign n_core = core_cnt;
    assign warm_rst_n = rst_q;
    // Counts the cycles for which each action stands high
    always @(posedge hclk) begin
        if (clear_active_state === 1'b1) clr_cnt <= clr_cnt + 1;
        if (core_system_reset === 1'b1) core_cnt <= core_cnt + 1;
    end
    // Warm reset pulse some cycles after the request rises
    always @(posedge hclk) begin
        if (warm_reset_request === 1'b1 && cnt < DLY + 2) cnt <= cnt + 1;
        else cnt <= 0;
        rst_q <= !(cnt == DLY);
    end
endmodule : vbrc_core_model

// *** testbench/tb.sv ***
// Register-level testbench of the vector base and reset control block
`timescale 1ns/1ps
module tb;
    logic hclk, por_n, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, vector_base_addr;
    logic [1:0] htrans;
    logic [2:0] hsize, priority_split_select;
    logic byte_order_flag, warm_reset_request, clear_active_state, core_system_reset;
    logic [7:0] priority_a, priority_b;
    logic a_preempts_b, a_before_b, warm_rst_n;
    int n_errors, n_checks, n_clear, n_core;
    localparam logic [31:0] VTB = 32'(vbrc_pkg::VTB_OFFSET);
    localparam logic [31:0] AIRC = 32'(vbrc_pkg::AIRC_OFFSET);
    localparam logic [31:0] KW = {vbrc_pkg::KEY_WRITE, 16'h0000};
    localparam logic [31:0] KR = {vbrc_pkg::KEY_READ, 16'h0000};
    // Table bases: all ones, then two offsets aligned to 32 words or to a larger power of two
    logic [31:0] vt [3] = '{32'hFFFFFFFF, 32'h00000400, 32'h20000200};
    // Priority pairs for the split scenarios
    logic [7:0] pa [2] = '{8'h34, 8'h4C};
    logic [7:0] pb [2] = '{8'h36, 8'h44};
    // Warm reset from the core model joins power-on reset
    assign hresetn = por_n & warm_rst_n;
    assign hready = hreadyout;
    vbrc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .vector_base_addr(vector_base_addr), .byte_order_flag(byte_order_flag),
        .priority_split_select(priority_split_select),
        .warm_reset_request(warm_reset_request), .clear_active_state(clear_active_state),
        .core_system_reset(core_system_reset), .priority_a(priority_a),
        .priority_b(priority_b), .a_preempts_b(a_preempts_b), .a_before_b(a_before_b));
    vbrc_core_model core (.hclk(hclk), .warm_reset_request(warm_reset_request),
        .clear_active_state(clear_active_state), .core_system_reset(core_system_reset),
        .warm_rst_n(warm_rst_n), .n_clear(n_clear), .n_core(n_core));
    // Clock of 8 ns
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Waits for an edge with hready high, bounded
    task wt;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k >= 50) n_errors++;
        if (k >= 50) close_out();
    endtask : wt
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
              output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= vbrc_pkg::HTRANS_NONSEQ;
        hsize <= vbrc_pkg::HSIZE_WORD;
        wt();
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        r = hrdata;
    endtask : xfer
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h00000000, r);
        check(r, e);
    endtask : rd
    // Main sequence
    initial begin
        int s, j, m, ea, eb;
        logic [31:0] v;
        logic [7:0] x, y;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {priority_a, priority_b, por_n} = '0;
        n_errors = 0;
        n_checks = 0;
        repeat (3) @(posedge hclk);
        por_n <= 1'b1;
        @(posedge hclk);
        rd(VTB, 32'h00000000);
        rd(AIRC, KR);
        check(32'(byte_order_flag), 32'h00000000);
        check(32'(hresp), 32'h00000000);
        rd(32'h00000010, 32'h00000000);
        foreach (vt[i]) begin
            v = vt[i];
            wr(VTB, v);
            repeat (2) @(posedge hclk);
            check(vector_base_addr, (v[29] ? vbrc_pkg::SRAM_REGION_BASE
                : vbrc_pkg::CODE_REGION_BASE) + (v & 32'h1FFFFF80));
            rd(VTB, v & 32'h3FFFFF80);
        end
        for (s = 0; s < 8; s++) begin
            wr(AIRC, KW | 32'h0000F800 | (32'(s) << 8));
            rd(AIRC, KR | (32'(s) << 8));
            check(32'(priority_split_select), 32'(s));
            m = (1 << (s + 1)) - 1;
            for (j = 0; j < 2; j++) begin
                x = pa[j];
                y = pb[j];
                priority_a <= x;
                priority_b <= y;
                ea = int'((x >> (s + 1)) < (y >> (s + 1)));
                eb = ea | int'((x >> (s + 1)) == (y >> (s + 1)) && (x & m) < (y & m));
                repeat (2) @(posedge hclk);
                check(32'(a_preempts_b), 32'(ea));
                check(32'(a_before_b), 32'(eb));
            end
        end
        wr(AIRC, 32'h05FB0307);
        rd(AIRC, KR | 32'h00000700);
        check(32'(n_clear + n_core), 32'h00000000);
        check(32'(warm_reset_request), 32'h00000000);
        // A read right after a keyed action write still sees its one-cycle pulse
        wr(AIRC, KW | 32'h00000302);
        rd(AIRC, KR | 32'h00000302);
        check(32'(n_clear), 32'h00000001);
        wr(AIRC, KW | 32'h00000301);
        rd(AIRC, KR | 32'h00000301);
        check(32'(n_core), 32'h00000001);
        wr(AIRC, KW | 32'h00000304);
        @(posedge hclk);
        check(32'(warm_reset_request), 32'h00000001);
        j = 0;
        while (warm_reset_request !== 1'b0 && j < 20) begin
            @(posedge hclk);
            j++;
        end
        check(32'(j < 20), 32'h00000001);
        repeat (2) @(posedge hclk);
        rd(AIRC, KR);
        close_out();
    end
endmodule : tb
